// >>> core/zlc_loop_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "zlc_defines.svh"
module zlc_loop_ctrl
(
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               nrst,
   // loop start in address and execute stages
   input  wire logic               ad_do_valid,
   input  wire zlc_pkg::zlc_do_type ad_do,
   input  wire logic               ex_do_valid,
   // execute stage position
   input  wire logic               ex_valid,
   input  wire logic [24:0]        ex_pc,
   // condition logic
   output logic [4:0]              test_cond,
   input  wire logic               cond_met,
   // explicit stack instructions
   input  wire logic               exp_push,
   input  wire logic               exp_pop,
   // fetch steering
   output logic                    loop_back,
   output logic                    loop_exit,
   output logic [24:0]             fetch_addr,
   // data memory bus
   input  wire zlc_pkg::zlc_dm_type data_memory_bus,
   output logic [31:0]             dm_rdata,
   // status and interrupt
   input  wire logic               ovf_irq_mask,
   output logic                    loop_ovf_irq,
   output logic                    loop_stacks_overflow_flag,
   output logic                    loop_stacks_empty_flag,
   output logic [31:0]             current_iteration_count
);
   import zlc_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   zlc_do_type   do_stage;
   zlc_lent_type lent;
   zlc_lent_type push_ent;
   zlc_lent_type next_ent;
   logic [63:0]  ls_top;
   logic [2:0]   ls_level;
   logic         ls_empty;
   logic         ls_push;
   logic         ls_pop;
   logic         ls_wr;
   logic         ovf_evt;
   logic [24:0]  pc_top;
   logic [2:0]   pc_level;
   logic         test_hit;
   logic         is_counter;
   logic         is_forever;
   logic         term;
   logic         test_true;
   logic         test_false;
   logic         dm_wr_loop_end_stack_top;
   logic         dm_wr_count;
   logic         dm_wr_status;
   logic         next_ovf;

   // ------------------------------------------------------------
   // loop context capture
   // ------------------------------------------------------------
   // context is latched in the address stage so the entry
   // to push is ready when the loop start executes
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         do_stage <= '0;
      else if (ad_do_valid)
         do_stage <= ad_do;                                // RULE3
   end

   assign push_ent.loop_end_stack_top = do_stage.loop_end_stack_top;                 // RULE7
   assign push_ent.count = do_stage.count;                 // RULE21

   // ------------------------------------------------------------
   // loop stack: address and count move as one entry
   // ------------------------------------------------------------
   assign ls_push = ex_do_valid || exp_push;               // RULE14
   assign ls_pop  = loop_exit || exp_pop;                  // RULE15

   zlc_stack
   #(
      .W (64)
   )
   u_loop_stack
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .push      (ls_push),
      .push_load (ex_do_valid),                            // RULE1
      .pop       (ls_pop),
      .wr_top    (ls_wr),
      .push_data (push_ent),
      .wr_data   (next_ent),
      .top       (ls_top),
      .level     (ls_level),
      .empty     (ls_empty),
      .ovf_evt   (ovf_evt)
   );                                                      // RULE10

   assign lent                    = ls_top;
   assign current_iteration_count = lent.count;            // RULE22

   // ------------------------------------------------------------
   // pc stack: top of loop addresses
   // ------------------------------------------------------------
   zlc_stack
   #(
      .W (25)
   )
   u_pc_stack
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .push      (ex_do_valid),
      .push_load (ex_do_valid),
      .pop       (loop_exit),
      .wr_top    (1'b0),
      .push_data (do_stage.top_pc),
      .wr_data   (25'h0),
      .top       (pc_top),
      .level     (pc_level),
      .empty     (),
      .ovf_evt   ()
   );                                                      // RULE2

   // ------------------------------------------------------------
   // termination test
   // ------------------------------------------------------------
   assign test_cond  = lent.loop_end_stack_top.cond;
   assign is_counter = (lent.loop_end_stack_top.ltype == zlc_lt_counter);
   assign is_forever = (lent.loop_end_stack_top.cond == `ZLC_COND_FOREVER) ||
                       (lent.loop_end_stack_top.ltype == zlc_lt_forever);

   // the test fires with e-4 in execute
   assign test_hit = ex_valid && !ls_empty &&
                     (ex_pc == lent.loop_end_stack_top.end_addr - `ZLC_TEST_DIST); // RULE4

   // zero count decrements to all ones and keeps looping
   always_comb
   begin
      if (is_forever)
         term = 1'b0;                                      // RULE19
      else if (is_counter)
         term = (lent.count == 32'h00000001);              // RULE16
      else
         term = cond_met;
   end

   assign test_true  = test_hit && term;
   assign test_false = test_hit && !term;

   // ------------------------------------------------------------
   // fetch steering and early pop
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         loop_back <= 1'b0;
         loop_exit <= 1'b0;
      end
      else
      begin
         loop_back <= test_false;                          // RULE5
         loop_exit <= test_true;                           // RULE6
      end
   end

   // exit pops the entry before the loop end executes, so the
   // top register already shows the enclosing loop
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         fetch_addr <= 25'h0;
      else if (test_true)
         fetch_addr <= lent.loop_end_stack_top.end_addr + 25'h1;        // RULE8
      else if (test_false)
         fetch_addr <= pc_top;                             // RULE5
   end

   // ------------------------------------------------------------
   // top entry updates
   // ------------------------------------------------------------
   assign dm_wr_loop_end_stack_top  = data_memory_bus.wr && (data_memory_bus.sel == zlc_reg_loop_end_stack_top);
   assign dm_wr_count  = data_memory_bus.wr && (data_memory_bus.sel == zlc_reg_count);
   assign dm_wr_status = data_memory_bus.wr && (data_memory_bus.sel == zlc_reg_status);

   // a bus write of the count wins over the decrement
   always_comb
   begin
      next_ent = lent;
      ls_wr    = 1'b0;
      if (dm_wr_loop_end_stack_top)
      begin
         next_ent.loop_end_stack_top = data_memory_bus.wdata;           // RULE12
         ls_wr          = 1'b1;
      end
      if (dm_wr_count)
      begin
         next_ent.count = data_memory_bus.wdata;           // RULE22
         ls_wr          = 1'b1;
      end
      else if (test_hit && is_counter)
      begin
         next_ent.count = lent.count - 32'h00000001;       // RULE4
         ls_wr          = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // status flags and interrupt
   // ------------------------------------------------------------
   // overflow set wins over a software clear in the same cycle
   always_comb
   begin
      next_ovf = loop_stacks_overflow_flag;
      if (ovf_evt)
         next_ovf = 1'b1;                                  // RULE17
      else if (dm_wr_status && !data_memory_bus.wdata[`ZLC_STS_OVF_BIT])
         next_ovf = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         loop_stacks_overflow_flag <= 1'b0;                // RULE24
      else
         loop_stacks_overflow_flag <= next_ovf;
   end

   assign loop_stacks_empty_flag = ls_empty;               // RULE18

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         loop_ovf_irq <= 1'b0;
      else
         loop_ovf_irq <= ovf_evt && !ovf_irq_mask;         // RULE11
   end

   // ------------------------------------------------------------
   // data memory bus read
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         dm_rdata <= 32'h0;
      else if (data_memory_bus.rd)
      begin
         if (data_memory_bus.sel == zlc_reg_loop_end_stack_top)
            dm_rdata <= lent.loop_end_stack_top;                        // RULE13
         else if (data_memory_bus.sel == zlc_reg_count)
            dm_rdata <= lent.count;                        // RULE22
         else if (data_memory_bus.sel == zlc_reg_status)
         begin
            dm_rdata                     <= 32'h0;
            dm_rdata[`ZLC_STS_OVF_BIT]   <= loop_stacks_overflow_flag;
            dm_rdata[`ZLC_STS_EMPTY_BIT] <= ls_empty;
         end
         else
            dm_rdata <= 32'h0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_push_depth: assert property ( // RULE1
      @(posedge mclk) disable iff (!nrst)
      ex_do_valid && !ls_pop && ls_level != `ZLC_DEPTH
      |=> ls_level == $past(ls_level) + 3'h1 && lent.loop_end_stack_top == $past(do_stage.loop_end_stack_top))
      else $error("loop start did not push loop entry");

   chk_pc_push: assert property ( // RULE2
      @(posedge mclk) disable iff (!nrst)
      ex_do_valid && !loop_exit && pc_level != `ZLC_DEPTH
      |=> pc_top == $past(do_stage.top_pc))
      else $error("top of loop not on pc stack");

   chk_stage_use: assert property ( // RULE3
      @(posedge mclk) disable iff (!nrst)
      ad_do_valid ##1 ex_do_valid && !ls_pop && ls_level != `ZLC_DEPTH
      |=> lent.loop_end_stack_top == $past(ad_do.loop_end_stack_top, 2))
      else $error("address stage context not pushed");

   chk_count_dec: assert property ( // RULE4
      @(posedge mclk) disable iff (!nrst)
      test_hit && is_counter && !dm_wr_count && !ls_push && !exp_pop && !loop_exit
      |=> current_iteration_count == $past(lent.count) - 32'h00000001)
      else $error("counter not decremented at test");

   chk_loop_back: assert property ( // RULE5
      @(posedge mclk) disable iff (!nrst)
      test_false |=> loop_back && !loop_exit && fetch_addr == $past(pc_top))
      else $error("loop back missing or wrong address");

   chk_exit_pop: assert property ( // RULE6
      @(posedge mclk) disable iff (!nrst)
      test_true && !ls_push && !exp_pop
      |=> loop_exit && fetch_addr == $past(lent.loop_end_stack_top.end_addr) + 25'h1
      ##1 ls_level == $past(ls_level, 2) - 3'h1)
      else $error("loop exit or pop missing");

   chk_depth_cap: assert property ( // RULE23
      @(posedge mclk) disable iff (!nrst)
      ls_level == `ZLC_DEPTH && ls_push && !ls_pop
      |=> ls_level == `ZLC_DEPTH && loop_stacks_overflow_flag)
      else $error("overflow push changed depth");

   chk_ovf_irq: assert property ( // RULE11
      @(posedge mclk) disable iff (!nrst)
      ls_level == `ZLC_DEPTH && ls_push && !ls_pop && !ovf_irq_mask |=> loop_ovf_irq)
      else $error("overflow interrupt not raised");

   chk_ptr_hold: assert property ( // RULE12
      @(posedge mclk) disable iff (!nrst)
      data_memory_bus.wr && !ls_push && !ls_pop |=> $stable(ls_level))
      else $error("register write moved stack pointer");

   chk_empty_read: assert property ( // RULE13
      @(posedge mclk) disable iff (!nrst)
      data_memory_bus.rd && data_memory_bus.sel == zlc_reg_loop_end_stack_top && ls_empty
      |=> dm_rdata == `ZLC_EMPTY_VAL)
      else $error("empty top read not all ones");

   chk_wrap: assert property ( // RULE16
      @(posedge mclk) disable iff (!nrst)
      test_hit && is_counter && !is_forever && lent.count == 32'h0 |=> !loop_exit)
      else $error("zero count ended loop");

   chk_ovf_sticky: assert property ( // RULE17
      @(posedge mclk) disable iff (!nrst)
      loop_stacks_overflow_flag && !dm_wr_status |=> loop_stacks_overflow_flag)
      else $error("overflow flag not sticky");

   chk_empty_clr: assert property ( // RULE18
      @(posedge mclk) disable iff (!nrst)
      ls_empty && ls_push |=> !loop_stacks_empty_flag)
      else $error("empty flag not cleared by push");

   chk_forever: assert property ( // RULE19
      @(posedge mclk) disable iff (!nrst)
      test_hit && is_forever |=> !loop_exit && loop_back)
      else $error("forever loop terminated");

endmodule
`default_nettype wire

// >>> core/zlc_defines.svh
// Operation
// (RULE1) loop start pushes loop end address and its condition onto loop stack
// (RULE2) loop start pushes the address after it onto the pc stack
// (RULE3) loop context is taken while the loop start sits in the address stage
// (RULE4) test and counter decrement happen when e-4 is in execute
// (RULE5) test false: fetch top of loop from pc stack next cycle
// (RULE6) test true: fall through past loop end and pop both stacks that cycle; the code pops at the next edge, at the end of the loop_exit cycle
// (RULE7) each loop entry holds end address, condition code and loop type
// (RULE8) during final four instructions the top register shows the next entry; the code pops after e-3, so only e-2 to e see it
// (RULE9) loop stack is six entries of 32 bits; a seventh push overflows
// (RULE10) counter and address stacks move together with one flag pair
// (RULE11) overflow raises a maskable interrupt request
// (RULE12) top register access over data bus never moves the pointer
// (RULE13) empty stack: top reads all ones and writes are ignored
// (RULE14) explicit push only moves the pointer, contents untouched
// (RULE15) explicit pop removes the top loop entry
// (RULE16) count of zero wraps, giving two to the 32 iterations
// (RULE17) status bit 25 is sticky overflow, cleared by software
// (RULE18) status bit 26 shows empty and clears on push
// (RULE19) forever condition never terminates the loop
// (RULE20) software must not touch the stacks while a loop runs
// (RULE21) counter loops load the count and push it onto the count stack
// (RULE22) empty count stack reads all ones, writes ignored, writes never push
// (RULE23) overflowing push keeps the six entries and sets overflow
// (RULE24) reset empties the stacks, sets empty and clears overflow
`ifndef ZLC_DEFINES_SVH
`define ZLC_DEFINES_SVH
`define ZLC_DEPTH         3'h6
`define ZLC_LEVEL_RST     3'h0
`define ZLC_EMPTY_VAL     32'hffffffff
`define ZLC_TEST_DIST     25'h0000004
`define ZLC_COND_FOREVER  5'h1f
`define ZLC_STS_OVF_BIT   25
`define ZLC_STS_EMPTY_BIT 26
`endif

// >>> core/zlc_pkg.sv
package zlc_pkg;

   typedef enum logic [1:0] {
      zlc_reg_loop_end_stack_top  = 2'b00,
      zlc_reg_count  = 2'b01,
      zlc_reg_status = 2'b10,
      zlc_reg_none   = 2'b11
   } zlc_reg_type;

   typedef enum logic [1:0] {
      zlc_lt_arith   = 2'b00,
      zlc_lt_counter = 2'b01,
      zlc_lt_forever = 2'b10,
      zlc_lt_rsvd    = 2'b11
   } zlc_ltype_type;

   typedef struct packed {
      zlc_ltype_type ltype;
      logic [4:0]    cond;
      logic [24:0]   end_addr;
   } zlc_loop_end_stack_top_type;

   typedef struct packed {
      zlc_loop_end_stack_top_type loop_end_stack_top;
      logic [31:0]   count;
   } zlc_lent_type;

   typedef struct packed {
      zlc_loop_end_stack_top_type loop_end_stack_top;
      logic [31:0]   count;
      logic [24:0]   top_pc;
   } zlc_do_type;

   typedef struct packed {
      zlc_reg_type sel;
      logic        rd;
      logic        wr;
      logic [31:0] wdata;
   } zlc_dm_type;

endpackage

// >>> core/zlc_stack.sv
`timescale 1ns/10ps
`default_nettype none
`include "zlc_defines.svh"
module zlc_stack
#(
   parameter int W = 32
)
(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         nrst,
   // stack operations
   input  wire logic         push,
   input  wire logic         push_load,
   input  wire logic         pop,
   input  wire logic         wr_top,
   input  wire logic [W-1:0] push_data,
   input  wire logic [W-1:0] wr_data,
   // state
   output logic [W-1:0]      top,
   output logic [2:0]        level,
   output logic              empty,
   output logic              ovf_evt
);
   logic [W-1:0] mem [`ZLC_DEPTH];
   logic         do_pop;
   logic         do_push;
   logic         load_en;
   logic         wr_en;
   logic [2:0]   top_idx;
   logic [2:0]   load_idx;
   logic [2:0]   next_level;

   assign empty    = (level == 3'h0);
   assign top_idx  = level - 3'h1;
   assign do_pop   = pop && !empty;
   assign do_push  = push && ((level != `ZLC_DEPTH) || do_pop);
   assign ovf_evt  = push && !do_push;                     // RULE9
   assign load_en  = push_load && do_push;                 // RULE14
   assign load_idx = do_pop ? top_idx : level;
   assign wr_en    = wr_top && !empty && !load_en;         // RULE13
   assign top      = empty ? '1 : mem[top_idx];            // RULE13

   always_comb
   begin
      next_level = level;
      if (do_push && !do_pop)
         next_level = level + 3'h1;
      else if (do_pop && !do_push)
         next_level = top_idx;
   end

   // overflowing push leaves level at six
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         level <= `ZLC_LEVEL_RST;                          // RULE24
      else
         level <= next_level;                              // RULE23
   end

   for (genvar i = 0; i < `ZLC_DEPTH; i++)
   begin : g_ent
      always_ff @(posedge mclk)
      begin
         if (load_en && load_idx == 3'(i))
            mem[i] <= push_data;
         else if (wr_en && top_idx == 3'(i))
            mem[i] <= wr_data;                             // RULE12
      end
   end
endmodule
`default_nettype wire

// >>> bench/zlc_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module zlc_fetch_model
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // run control from the bench
   input  wire logic        go,
   input  wire logic [24:0] start_pc,
   // steering from the sequencer
   input  wire logic        loop_back,
   input  wire logic        loop_exit,
   input  wire logic [24:0] fetch_addr,
   // execute stage
   output logic             ex_valid,
   output logic [24:0]      ex_pc
);
   logic [1:0]  rem;
   logic [24:0] tgt;

   // ----------------------------------------
   // execute stream, never pushes or pops the stacks
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst || !go)
      begin
         ex_valid <= 1'b0;
         ex_pc    <= ~ex_pc;
         rem      <= 2'h0;
      end
      else if (!ex_valid)
      begin
         ex_valid <= 1'b1;
         ex_pc    <= start_pc;
      end
      else if (loop_back || loop_exit)
      begin
         // e-3 .. e still drain before the redirect lands
         ex_pc <= ex_pc + 25'h1;
         rem   <= 2'h3;
         tgt   <= fetch_addr;
      end
      else if (rem == 2'h1)
      begin
         ex_pc <= tgt;
         rem   <= 2'h0;
      end
      else
      begin
         ex_pc <= ex_pc + 25'h1;
         rem   <= rem - {1'b0, rem != 2'h0};
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import zlc_pkg::*;
   localparam logic [31:0] ones = 32'hffffffff;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        ad_do_valid = 1'b0;
   zlc_do_type  ad_do = '0;
   logic        ex_do_valid = 1'b0;
   logic        ex_valid;
   logic [24:0] ex_pc;
   logic [4:0]  test_cond;
   logic        cond_met = 1'b0;
   logic        exp_push = 1'b0;
   logic        exp_pop = 1'b0;
   logic        loop_back;
   logic        loop_exit;
   logic [24:0] fetch_addr;
   zlc_dm_type  dm = '0;
   logic [31:0] dm_rdata;
   logic        ovf_irq_mask = 1'b0;
   logic        loop_ovf_irq;
   logic        ovf_f;
   logic        emp_f;
   logic [31:0] cur_cnt;
   logic        go = 1'b0;
   logic [24:0] start_pc = 25'h0;
   logic [31:0] rv;
   logic [31:0] last_cnt;
   logic        seen;
   int          err_total = 0;
   int          n_tests = 0;

   always #12.5 mclk = ~mclk;

   zlc_loop_ctrl zlc_loop_ctrl_inst (.mclk, .nrst, .ad_do_valid, .ad_do, .ex_do_valid,
      .ex_valid, .ex_pc, .test_cond, .cond_met, .exp_push, .exp_pop, .loop_back,
      .loop_exit, .fetch_addr, .data_memory_bus(dm), .dm_rdata, .ovf_irq_mask,
      .loop_ovf_irq, .loop_stacks_overflow_flag(ovf_f), .loop_stacks_empty_flag(emp_f),
      .current_iteration_count(cur_cnt));

   zlc_fetch_model zlc_fetch_model_inst (.mclk, .nrst, .go, .start_pc, .loop_back,
      .loop_exit, .fetch_addr, .ex_valid, .ex_pc);

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task tick;
      @(posedge mclk);
      #1;
   endtask

   task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task end_of_test;
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task rd(input zlc_reg_type s, output logic [31:0] d);
      dm.sel = s;
      dm.rd = 1'b1;
      tick;
      dm.rd = 1'b0;
      d = dm_rdata;
      tick;
   endtask

   task wr(input zlc_reg_type s, input logic [31:0] v);
      dm.sel = s;
      dm.wdata = v;
      dm.wr = 1'b1;
      tick;
      dm.wr = 1'b0;
      tick;
   endtask

   task stk(input logic p);
      exp_push = p;
      exp_pop = !p;
      tick;
      exp_push = 1'b0;
      exp_pop = 1'b0;
      tick;
   endtask

   task ovf_push;
      exp_push = 1'b1;
      seen = 1'b0;
      repeat (3)
      begin
         tick;
         exp_push = 1'b0;
         seen = seen | loop_ovf_irq;
      end
   endtask

   task push_loop(input zlc_ltype_type lt, input logic [4:0] c, input logic [24:0] e,
                  input logic [31:0] n, input logic [24:0] t);
      ad_do = {lt, c, e, n, t};
      ad_do_valid = 1'b1;
      tick;
      ad_do_valid = 1'b0;
      // context must already be held from the address stage
      ad_do = '1;
      ex_do_valid = 1'b1;
      tick;
      ex_do_valid = 1'b0;
      tick;
   endtask

   task run_loop(input logic [24:0] t, input logic [24:0] e, input int nb, input logic ex);
      int   b;
      int   i;
      logic x;
      b = 0;
      x = 1'b0;
      start_pc = t;
      go = 1'b1;
      for (i = 0; i < 400; i++)
      begin
         tick;
         if (loop_back)
         begin
            check("back_pc", 32'(fetch_addr), 32'(t));
            last_cnt = cur_cnt;
            b++;
            if (!ex && b == nb)
               break;
         end
         if (loop_exit)
         begin
            check("exit_pc", 32'(fetch_addr), 32'(e + 25'h1));
            x = 1'b1;
            break;
         end
      end
      if (i == 400)
      begin
         err_total++;
         end_of_test;
      end
      go = 1'b0;
      // an exit pops the stacks at the next edge, let that land first
      tick;
      check("backs", 32'(b), 32'(nb));
      check("exited", 32'(x), 32'(ex));
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      check("empty", 32'(emp_f), 32'h1);
      check("ovf", 32'(ovf_f), 32'h0);
      wr(zlc_reg_loop_end_stack_top, 32'h12345678);
      rd(zlc_reg_loop_end_stack_top, rv);
      check("loop_end_stack_top_e", rv, ones);
      wr(zlc_reg_count, 32'h5);
      rd(zlc_reg_count, rv);
      check("count_e", rv, ones);
      check("cur_e", cur_cnt, ones);
      rd(zlc_reg_status, rv);
      check("sts_e", rv, 32'h04000000);
   endtask

   task t_nested;
      push_loop(zlc_lt_arith, 5'h03, 25'h20f, 32'h0, 25'h200);
      push_loop(zlc_lt_counter, 5'h0f, 25'h107, 32'h3, 25'h100);
      check("cond", 32'(test_cond), 32'h0f);
      rd(zlc_reg_loop_end_stack_top, rv);
      check("loop_end_stack_top", rv, {zlc_lt_counter, 5'h0f, 25'h107});
      check("cur", cur_cnt, 32'h3);
      check("nonempty", 32'(emp_f), 32'h0);
      run_loop(25'h100, 25'h107, 2, 1'b1);
      check("cnt_dec", last_cnt, 32'h1);
      rd(zlc_reg_loop_end_stack_top, rv);
      check("loop_end_stack_top_next", rv, {zlc_lt_arith, 5'h03, 25'h20f});
      cond_met = 1'b1;
      run_loop(25'h200, 25'h20f, 0, 1'b1);
      cond_met = 1'b0;
      check("empty_end", 32'(emp_f), 32'h1);
   endtask

   task t_wrap;
      push_loop(zlc_lt_counter, 5'h0f, 25'h107, 32'h0, 25'h100);
      run_loop(25'h100, 25'h107, 1, 1'b0);
      check("wrap", last_cnt, ones);
      wr(zlc_reg_count, 32'h1);
      run_loop(25'h100, 25'h107, 0, 1'b1);
      check("empty_w", 32'(emp_f), 32'h1);
   endtask

   task t_forever;
      push_loop(zlc_lt_forever, 5'h1f, 25'h107, 32'h1, 25'h100);
      cond_met = 1'b1;
      run_loop(25'h100, 25'h107, 3, 1'b0);
      cond_met = 1'b0;
      check("fv_live", 32'(emp_f), 32'h0);
      stk(1'b0);
      check("fv_pop", 32'(emp_f), 32'h1);
   endtask

   task t_overflow;
      stk(1'b1);
      wr(zlc_reg_loop_end_stack_top, 32'h4a5c3e01);
      stk(1'b0);
      stk(1'b1);
      rd(zlc_reg_loop_end_stack_top, rv);
      check("push_keep", rv, 32'h4a5c3e01);
      repeat (5) stk(1'b1);
      wr(zlc_reg_loop_end_stack_top, 32'h00000abc);
      check("ovf_6", 32'(ovf_f), 32'h0);
      ovf_push;
      check("irq", 32'(seen), 32'h1);
      check("ovf_7", 32'(ovf_f), 32'h1);
      ovf_irq_mask = 1'b1;
      ovf_push;
      ovf_irq_mask = 1'b0;
      check("irq_mask", 32'(seen), 32'h0);
      rd(zlc_reg_loop_end_stack_top, rv);
      check("top_kept", rv, 32'h00000abc);
      rd(zlc_reg_status, rv);
      check("sts_ovf", rv, 32'h02000000);
      wr(zlc_reg_status, 32'h0);
      rd(zlc_reg_status, rv);
      check("sts_clr", rv, 32'h0);
      repeat (5) stk(1'b0);
      check("depth6", 32'(emp_f), 32'h0);
      stk(1'b0);
      rd(zlc_reg_status, rv);
      check("sts_end", rv, 32'h04000000);
   endtask

   initial
   begin
      repeat (2) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset;
      t_nested;
      t_wrap;
      t_forever;
      t_overflow;
      end_of_test;
   end
endmodule
`default_nettype wire
